// ### common/ddc_nco_map.svh
`ifndef DDC_NCO_MAP_SVH
`define DDC_NCO_MAP_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define OFS_UPDATE_MODE 9'h164
`define OFS_SEL_CTRL 9'h165
`define OFS_PATH_FREQ_SEL 9'h166
`define OFS_DECIM_LOW 9'h167
`define OFS_DECIM_HIGH 9'h168
`define OFS_DECIM_MODE 9'h169

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define RST_UPDATE_MODE 8'h00
`define RST_SEL_CTRL 8'h00
`define RST_PATH_FREQ_SEL 8'h00
`define RST_DECIM_LOW 8'h00
`define RST_DECIM_HIGH 8'h00
`define RST_DECIM_MODE 8'h00
`define RST_READ_DATA 8'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define BIT_OSC_UPDATE_LSB 4
`define BIT_NEG_IMAGE 3
`define BIT_OSC_MODE 0
`define BIT_LOW_LATENCY 4
`define BIT_AUTO_UPD_DIS 2
`define BIT_SEL_SOURCE 1
`define BIT_COMMON_UPDATE 0
`define BIT_UNEQUAL_DECIM 7
`define BIT_PATH_COUNT_LSB 4
`define BIT_COMMON_DECIM_LSB 0
`define BIT_ODD_DECIM_LSB 4
`define BIT_EVEN_DECIM_LSB 0

// -----------------------------------------------------------------
// path-count codes and path enables
// -----------------------------------------------------------------
`define PATHS_DUAL 2'h0
`define PATHS_QUAD 2'h1
`define PATHS_SINGLE 2'h2
`define EN_DUAL 4'h3
`define EN_QUAD 4'hF
`define EN_SINGLE 4'h1
`define EN_NONE 4'h0

`endif

// ### common/ddc_nco_pkg.sv
package ddc_nco_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [3:0] decim_code_t;
   typedef logic [15:0] decim_ratio_t;
   typedef logic [8:0] reg_addr_t;
endpackage

// ### logic/osc_load_pulse.sv
`include "ddc_nco_map.svh"

module osc_load_pulse
   import ddc_nco_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [3:0] osc_rise_in,
   input wire logic common_rise_in,
   input wire logic [3:0] auto_req_in,
   output logic [3:0] osc_load_out
);
   logic [3:0] load_d;
   logic [3:0] load_q;

   // -----------------------------------------------------------------
   // one load pulse per oscillator
   // -----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_osc
         always_comb begin
            // (R1) (R2) (R6) merge load causes
            load_d[i] = osc_rise_in[i] | common_rise_in | auto_req_in[i];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         load_q <= 4'h0;
      end else begin
         load_q <= load_d;
      end
   end

   assign osc_load_out = load_q;
endmodule // osc_load_pulse

// ### logic/decim_path_config.sv
`include "ddc_nco_map.svh"

module decim_path_config
   import ddc_nco_pkg::*;
(
   input wire reg_byte_t decim_mode_in,
   input wire reg_byte_t decim_low_in,
   input wire reg_byte_t decim_high_in,
   input wire logic low_latency_in,
   output logic [15:0] code_out,
   output logic [63:0] ratio_out,
   output logic [3:0] enable_out
);
   // code n means divide by two to the n; code 0 is bypass, ratio 1
   function automatic decim_ratio_t ratio_of(input decim_code_t code);
      ratio_of = decim_ratio_t'(16'h0001 << code);
   endfunction

   decim_code_t common_code;
   decim_code_t path_code [4];
   logic [1:0] count;

   assign common_code = decim_mode_in[`BIT_COMMON_DECIM_LSB +: 4];
   assign count = decim_mode_in[`BIT_PATH_COUNT_LSB +: 2];
   // (R10) nibble per path
   assign path_code[0] = decim_low_in[`BIT_EVEN_DECIM_LSB +: 4];
   assign path_code[1] = decim_low_in[`BIT_ODD_DECIM_LSB +: 4];
   assign path_code[2] = decim_high_in[`BIT_EVEN_DECIM_LSB +: 4];
   assign path_code[3] = decim_high_in[`BIT_ODD_DECIM_LSB +: 4];

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_path
         always_comb begin
            // (R12) (R13) (R15) common or own factor
            if (decim_mode_in[`BIT_UNEQUAL_DECIM]) begin
               code_out[4*i +: 4] = path_code[i];
            end else begin
               code_out[4*i +: 4] = common_code;
            end
            // (R11) (R16) code to ratio
            ratio_out[16*i +: 16] = ratio_of(code_out[4*i +: 4]);
         end
      end
   endgenerate

   always_comb begin
      // (R14) active path count
      case (count)
         `PATHS_DUAL: enable_out = `EN_DUAL;
         `PATHS_QUAD: enable_out = `EN_QUAD;
         `PATHS_SINGLE: enable_out = `EN_SINGLE;
         default: enable_out = `EN_NONE;
      endcase
      // (R5) low latency skips every path
      if (low_latency_in) begin
         enable_out = `EN_NONE;
      end
   end
endmodule // decim_path_config

// ### logic/ddc_nco_control_regs.sv
`include "ddc_nco_map.svh"

// Summary of operation
// (R1) 0-to-1 update bit loads that oscillator
// (R2) 0-to-1 common bit loads all oscillators
// (R3) negative image only in complex mode
// (R4) mode bit: continuous or phase coherent
// (R5) low latency bypasses all processing
// (R6) auto-update disable blocks pin-driven loads
// (R7) source bit: pins or select register
// (R8) two-bit frequency select per path
// (R9) software sets source bit for register select
// (R10) decimation nibbles: odd high, even low
// (R11) decimation codes map to powers of two
// (R12) per-path factors only with unequal enable
// (R13) unequal bit: common or per-path factor
// (R14) path count: dual, quad, single, unused
// (R15) common field sets all active paths
// (R16) code n divides by two to n
// (R17) software writes zeros to reserved bits
module ddc_nco_control_regs
   import ddc_nco_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire reg_addr_t reg_addr_in,
   input wire reg_byte_t reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output reg_byte_t reg_rdata_out,
   input wire logic [7:0] gpio_freq_sel_in,
   input wire logic complex_decimation_enable_in,
   output logic [3:0] osc_load_out,
   output logic [7:0] active_freq_sel_out,
   output logic phase_coherent_out,
   output logic negative_image_select_out,
   output logic low_latency_out,
   output logic [15:0] path_decim_code_out,
   output logic [63:0] path_decim_ratio_out,
   output logic [3:0] path_enable_out
);
   function automatic logic wr_hit(input reg_addr_t a, input reg_addr_t ofs,
                                   input logic wr);
      wr_hit = wr && (a == ofs);
   endfunction

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   reg_byte_t upd_mode_d, upd_mode_q;
   reg_byte_t sel_ctrl_d, sel_ctrl_q;
   reg_byte_t freq_sel_d, freq_sel_q;
   reg_byte_t decim_low_d, decim_low_q;
   reg_byte_t decim_high_d, decim_high_q;
   reg_byte_t decim_mode_d, decim_mode_q;
   reg_byte_t rdata_d, rdata_q;

   always_comb begin
      upd_mode_d = upd_mode_q;
      sel_ctrl_d = sel_ctrl_q;
      freq_sel_d = freq_sel_q;
      decim_low_d = decim_low_q;
      decim_high_d = decim_high_q;
      decim_mode_d = decim_mode_q;
      rdata_d = rdata_q;
      // reserved bits are stored as written; software keeps them zero
      if (wr_hit(reg_addr_in, `OFS_UPDATE_MODE, reg_wr_in)) begin
         upd_mode_d = reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `OFS_SEL_CTRL, reg_wr_in)) begin
         sel_ctrl_d = reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `OFS_PATH_FREQ_SEL, reg_wr_in)) begin
         freq_sel_d = reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `OFS_DECIM_LOW, reg_wr_in)) begin
         decim_low_d = reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `OFS_DECIM_HIGH, reg_wr_in)) begin
         decim_high_d = reg_wdata_in;
      end
      if (wr_hit(reg_addr_in, `OFS_DECIM_MODE, reg_wr_in)) begin
         decim_mode_d = reg_wdata_in;
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `OFS_UPDATE_MODE: rdata_d = upd_mode_q;
            `OFS_SEL_CTRL: rdata_d = sel_ctrl_q;
            `OFS_PATH_FREQ_SEL: rdata_d = freq_sel_q;
            `OFS_DECIM_LOW: rdata_d = decim_low_q;
            `OFS_DECIM_HIGH: rdata_d = decim_high_q;
            `OFS_DECIM_MODE: rdata_d = decim_mode_q;
            default: rdata_d = `RST_READ_DATA;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         upd_mode_q <= `RST_UPDATE_MODE;
         sel_ctrl_q <= `RST_SEL_CTRL;
         freq_sel_q <= `RST_PATH_FREQ_SEL;
         decim_low_q <= `RST_DECIM_LOW;
         decim_high_q <= `RST_DECIM_HIGH;
         decim_mode_q <= `RST_DECIM_MODE;
         rdata_q <= `RST_READ_DATA;
      end else begin
         upd_mode_q <= upd_mode_d;
         sel_ctrl_q <= sel_ctrl_d;
         freq_sel_q <= freq_sel_d;
         decim_low_q <= decim_low_d;
         decim_high_q <= decim_high_d;
         decim_mode_q <= decim_mode_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // -----------------------------------------------------------------
   // update strobes and pin-driven selection
   // -----------------------------------------------------------------
   logic [3:0] osc_rise;
   logic common_rise;
   logic [3:0] auto_req;
   logic [7:0] gpio_prev_d, gpio_prev_q;
   logic [7:0] active_sel_d, active_sel_q;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_osc
         always_comb begin
            // (R1) edge seen against the stored bit
            osc_rise[i] = wr_hit(reg_addr_in, `OFS_UPDATE_MODE, reg_wr_in)
               && reg_wdata_in[`BIT_OSC_UPDATE_LSB + i]
               && !upd_mode_q[`BIT_OSC_UPDATE_LSB + i];
            // (R6) pin switch loads unless disabled or register-sourced
            auto_req[i] = (gpio_freq_sel_in[2*i +: 2] != gpio_prev_q[2*i +: 2])
               && !sel_ctrl_q[`BIT_SEL_SOURCE]
               && !sel_ctrl_q[`BIT_AUTO_UPD_DIS];
         end
      end
   endgenerate

   always_comb begin
      // (R2) common update edge
      common_rise = wr_hit(reg_addr_in, `OFS_SEL_CTRL, reg_wr_in)
         && reg_wdata_in[`BIT_COMMON_UPDATE]
         && !sel_ctrl_q[`BIT_COMMON_UPDATE];
      gpio_prev_d = gpio_freq_sel_in;
      // (R7) (R8) selection source per path
      if (sel_ctrl_q[`BIT_SEL_SOURCE]) begin
         active_sel_d = freq_sel_q;
      end else begin
         active_sel_d = gpio_freq_sel_in;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         gpio_prev_q <= 8'h00;
         active_sel_q <= 8'h00;
      end else begin
         gpio_prev_q <= gpio_prev_d;
         active_sel_q <= active_sel_d;
      end
   end

   assign active_freq_sel_out = active_sel_q;

   osc_load_pulse u_load (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .osc_rise_in(osc_rise),
      .common_rise_in(common_rise),
      .auto_req_in(auto_req),
      .osc_load_out(osc_load_out)
   );

   // -----------------------------------------------------------------
   // mode outputs and decimation
   // -----------------------------------------------------------------
   logic [15:0] code_c;
   logic [63:0] ratio_c;
   logic [3:0] enable_c;
   logic coherent_d, coherent_q;
   logic neg_image_d, neg_image_q;
   logic low_lat_d, low_lat_q;
   logic [15:0] code_d, code_q;
   logic [63:0] ratio_d, ratio_q;
   logic [3:0] enable_d, enable_q;

   decim_path_config u_decim (
      .decim_mode_in(decim_mode_q),
      .decim_low_in(decim_low_q),
      .decim_high_in(decim_high_q),
      .low_latency_in(sel_ctrl_q[`BIT_LOW_LATENCY]),
      .code_out(code_c),
      .ratio_out(ratio_c),
      .enable_out(enable_c)
   );

   always_comb begin
      // (R4) oscillator switching mode
      coherent_d = upd_mode_q[`BIT_OSC_MODE];
      // (R3) gated by complex decimation
      neg_image_d = upd_mode_q[`BIT_NEG_IMAGE] && complex_decimation_enable_in;
      // (R5) low latency flag
      low_lat_d = sel_ctrl_q[`BIT_LOW_LATENCY];
      code_d = code_c;
      ratio_d = ratio_c;
      enable_d = enable_c;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         coherent_q <= 1'b0;
         neg_image_q <= 1'b0;
         low_lat_q <= 1'b0;
         code_q <= 16'h0000;
         ratio_q <= {4{16'h0001}};
         enable_q <= `EN_DUAL;
      end else begin
         coherent_q <= coherent_d;
         neg_image_q <= neg_image_d;
         low_lat_q <= low_lat_d;
         code_q <= code_d;
         ratio_q <= ratio_d;
         enable_q <= enable_d;
      end
   end

   assign phase_coherent_out = coherent_q;
   assign negative_image_select_out = neg_image_q;
   assign low_latency_out = low_lat_q;
   assign path_decim_code_out = code_q;
   assign path_decim_ratio_out = ratio_q;
   assign path_enable_out = enable_q;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   AST_OSC0_LOAD: assert property ( // (R1)
      @(posedge clk_sys_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == `OFS_UPDATE_MODE && reg_wdata_in[4]
       && !upd_mode_q[4]) |=> osc_load_out[0])
      else $error("oscillator 0 update edge gave no load");

   AST_COMMON_LOAD: assert property ( // (R2)
      @(posedge clk_sys_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == `OFS_SEL_CTRL && reg_wdata_in[0]
       && !sel_ctrl_q[0]) |=> (osc_load_out == 4'hF))
      else $error("common update did not load all oscillators");

   AST_NEG_IMAGE_REAL: assert property ( // (R3)
      @(posedge clk_sys_in) disable iff (rst_in)
      !complex_decimation_enable_in |=> !negative_image_select_out)
      else $error("negative image active outside complex mode");

   AST_MODE_WRITE: assert property ( // (R4)
      @(posedge clk_sys_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == `OFS_UPDATE_MODE)
      |=> ##1 (phase_coherent_out == $past(reg_wdata_in[0], 2)))
      else $error("oscillator mode not applied two cycles after write");

   AST_LOW_LAT: assert property ( // (R5)
      @(posedge clk_sys_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == `OFS_SEL_CTRL && reg_wdata_in[4])
      |=> ##1 (low_latency_out && path_enable_out == 4'h0))
      else $error("low latency did not bypass the paths");

   AST_AUTO_DIS: assert property ( // (R6)
      @(posedge clk_sys_in) disable iff (rst_in)
      (sel_ctrl_q[2] && !reg_wr_in) |=> (osc_load_out == 4'h0))
      else $error("load issued while auto update disabled");

   AST_SEL_SOURCE: assert property ( // (R7)
      @(posedge clk_sys_in) disable iff (rst_in)
      sel_ctrl_q[1] |=> (active_freq_sel_out == $past(freq_sel_q)))
      else $error("register selection not followed");

   AST_PIN_SOURCE: assert property ( // (R7)
      @(posedge clk_sys_in) disable iff (rst_in)
      !sel_ctrl_q[1]
      |=> (active_freq_sel_out == $past(gpio_freq_sel_in)))
      else $error("pin selection not followed");

   AST_UNEQUAL_DECIM: assert property ( // (R12)
      @(posedge clk_sys_in) disable iff (rst_in)
      decim_mode_q[7]
      |=> (path_decim_code_out == {$past(decim_high_q), $past(decim_low_q)}))
      else $error("per-path decimation factors not applied");

   AST_COMMON_DECIM: assert property ( // (R13)
      @(posedge clk_sys_in) disable iff (rst_in)
      !decim_mode_q[7]
      |=> (path_decim_code_out[15:12] == $past(decim_mode_q[3:0])))
      else $error("common decimation not applied to path 3");

   AST_SINGLE_PATH: assert property ( // (R14)
      @(posedge clk_sys_in) disable iff (rst_in)
      (decim_mode_q[5:4] == 2'h2 && !sel_ctrl_q[4])
      |=> (path_enable_out == 4'h1))
      else $error("single path mode enabled wrong paths");

   AST_RATIO: assert property ( // (R11)
      @(posedge clk_sys_in) disable iff (rst_in)
      path_decim_ratio_out[31:16] == (16'h0001 << path_decim_code_out[7:4]))
      else $error("path 1 ratio does not match its code");
endmodule // ddc_nco_control_regs

// ### test/tb_top.sv
`include "ddc_nco_map.svh"

module tb_top
   import ddc_nco_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // stimulus and design
   // ---------------------------------------------------------------
   logic clk_sys_in;
   logic rst_in;
   reg_addr_t addr;
   reg_byte_t wdata;
   reg_byte_t rdata;
   logic wr;
   logic rd;
   logic [7:0] gpio;
   logic cplx;
   logic [3:0] osc_load;
   logic [7:0] act_sel;
   logic phase_coh;
   logic neg_img;
   logic low_lat;
   logic [15:0] dcode;
   logic [63:0] dratio;
   logic [3:0] pen;
   int failures;
   int checked;
   int cycles;

   ddc_nco_control_regs i_dut (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_wr_in(wr),
      .reg_rd_in(rd),
      .reg_rdata_out(rdata),
      .gpio_freq_sel_in(gpio),
      .complex_decimation_enable_in(cplx),
      .osc_load_out(osc_load),
      .active_freq_sel_out(act_sel),
      .phase_coherent_out(phase_coh),
      .negative_image_select_out(neg_img),
      .low_latency_out(low_lat),
      .path_decim_code_out(dcode),
      .path_decim_ratio_out(dratio),
      .path_enable_out(pen)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_byte(input reg_byte_t got, input reg_byte_t exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t register got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t output got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input reg_addr_t a, input reg_byte_t d);
      @(posedge clk_sys_in);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk_sys_in);
      #1;
      wr = 1'b0;
   endtask

   task automatic rd_reg(input reg_addr_t a, output reg_byte_t d);
      @(posedge clk_sys_in);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk_sys_in);
      #1;
      rd = 1'b0;
      d = rdata;
   endtask

   task automatic settle();
      repeat (3) @(posedge clk_sys_in);
      #1;
   endtask

   // a load must show as exactly one pulse in the next few cycles
   task automatic watch_load(input logic [3:0] exp);
      logic [3:0] seen;
      int n;
      seen = 4'h0;
      n = 0;
      for (int i = 0; i < 5; i++) begin
         if (osc_load !== 4'h0) begin
            seen = seen | osc_load;
            n++;
         end
         @(posedge clk_sys_in);
         #1;
      end
      chk_out(64'(seen), 64'(exp));
      chk_out(64'(n), (exp != 4'h0) ? 64'h1 : 64'h0);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_rw();
      reg_byte_t d;
      reg_addr_t ofs[6];
      reg_byte_t pat[6];
      ofs = '{`OFS_UPDATE_MODE, `OFS_SEL_CTRL, `OFS_PATH_FREQ_SEL,
              `OFS_DECIM_LOW, `OFS_DECIM_HIGH, `OFS_DECIM_MODE};
      // reserved bits are left zero in every pattern
      pat = '{8'hF9, 8'h17, 8'hA5, 8'h5A, 8'hC3, 8'hBA};
      chk_out(64'(pen), 64'h3); // dual paths at reset
      chk_out(dratio, 64'h0001_0001_0001_0001); // bypass ratio
      for (int i = 0; i < 6; i++) begin
         rd_reg(ofs[i], d);
         chk_byte(d, 8'h00); // reset value
         wr_reg(ofs[i], pat[i]); // reserved bits zero
         rd_reg(ofs[i], d);
         chk_byte(d, pat[i]); // fields read back
         wr_reg(ofs[i], 8'h00); // reserved bits zero
      end
      wr_reg(9'h16A, 8'hFF);
      rd_reg(9'h16A, d);
      chk_byte(d, 8'h00); // unmapped reads zero
      rd_reg(`OFS_DECIM_MODE, d);
      chk_byte(d, 8'h00); // no alias written
   endtask

   task automatic t_update();
      wr_reg(`OFS_UPDATE_MODE, 8'h10);
      watch_load(4'h1); // single oscillator
      wr_reg(`OFS_UPDATE_MODE, 8'h30);
      watch_load(4'h2); // only new rising bit
      wr_reg(`OFS_UPDATE_MODE, 8'h30);
      watch_load(4'h0); // no rise no load
      wr_reg(`OFS_UPDATE_MODE, 8'hF0);
      watch_load(4'hC); // two at once
      wr_reg(`OFS_UPDATE_MODE, 8'h00);
      watch_load(4'h0); // falling edge ignored
      wr_reg(`OFS_SEL_CTRL, 8'h01);
      watch_load(4'hF); // all oscillators
      wr_reg(`OFS_SEL_CTRL, 8'h01);
      watch_load(4'h0); // held bit no load
      wr_reg(`OFS_SEL_CTRL, 8'h00);
   endtask

   task automatic t_modes();
      wr_reg(`OFS_UPDATE_MODE, 8'h09);
      settle();
      chk_out(64'(phase_coh), 64'h1); // coherent mode
      chk_out(64'(neg_img), 64'h0); // real mode blocks image
      cplx = 1'b1;
      settle();
      chk_out(64'(neg_img), 64'h1); // complex mode image
      wr_reg(`OFS_UPDATE_MODE, 8'h00);
      settle();
      chk_out(64'(phase_coh), 64'h0); // continuous mode
      chk_out(64'(neg_img), 64'h0); // image cleared
      wr_reg(`OFS_SEL_CTRL, 8'h10);
      settle();
      chk_out(64'(low_lat), 64'h1); // bypass on
      chk_out(64'(pen), 64'h0); // processing bypassed
      wr_reg(`OFS_SEL_CTRL, 8'h00);
      settle();
      chk_out(64'(low_lat), 64'h0); // bypass off
      chk_out(64'(pen), 64'h3); // normal paths back
   endtask

   task automatic t_select();
      gpio = 8'h04;
      watch_load(4'h2); // pin switch loads path
      chk_out(64'(act_sel), 64'h04); // pins select
      gpio = 8'h44;
      watch_load(4'h8); // pin switch on path three
      wr_reg(`OFS_SEL_CTRL, 8'h04);
      settle();
      gpio = 8'h4C;
      watch_load(4'h0); // auto update blocked
      wr_reg(`OFS_PATH_FREQ_SEL, 8'hE4);
      wr_reg(`OFS_SEL_CTRL, 8'h02); // source bit with fields
      settle();
      chk_out(64'(act_sel), 64'hE4); // register fields per path
      gpio = 8'h00;
      watch_load(4'h0); // pins ignored
      chk_out(64'(act_sel), 64'hE4); // register source kept
      wr_reg(`OFS_SEL_CTRL, 8'h00);
      settle();
   endtask

   task automatic t_decim();
      logic [3:0] en_tab[4];
      logic [3:0] codes[5];
      en_tab = '{4'h3, 4'hF, 4'h1, 4'h0};
      codes = '{4'h0, 4'h1, 4'h2, 4'hE, 4'hF};
      for (int c = 0; c < 4; c++) begin
         wr_reg(`OFS_DECIM_MODE, 8'(c << 4) | 8'h03);
         settle();
         chk_out(64'(pen), 64'(en_tab[c])); // path count code
      end
      for (int i = 0; i < 5; i++) begin
         wr_reg(`OFS_DECIM_MODE, 8'h10 | 8'(codes[i]));
         settle();
         chk_out(64'(dcode), 64'({4{codes[i]}})); // shared code
         chk_out(64'(dratio[15:0]), 64'(16'h0001 << codes[i]));
      end
      wr_reg(`OFS_DECIM_LOW, 8'h21);
      wr_reg(`OFS_DECIM_HIGH, 8'h43);
      settle();
      chk_out(64'(dcode), 64'hFFFF); // ignored while common
      wr_reg(`OFS_DECIM_MODE, 8'h9F);
      settle();
      chk_out(64'(dcode), 64'h4321); // per path nibbles
      chk_out(dratio, 64'h0010_0008_0004_0002); // per path ratio
   endtask

   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   // budget is a few hundred cycles, so this only trips on a hang
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("ERROR %0t run timed out", $time);
         final_report();
      end
   end

   initial begin
      failures = 0;
      checked = 0;
      cycles = 0;
      rst_in = 1'b1;
      addr = 9'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      gpio = 8'h00;
      cplx = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
      t_reset_rw();
      t_update();
      t_modes();
      t_select();
      t_decim();
      final_report();
   end
endmodule // tb_top
